/* cbwa_pkg.sv */
// package: shared constants and types for the write-end and dma arbiter
package cbwa_pkg;
  localparam int CBWA_AD_W = 32;
  localparam int CBWA_IDX_W = 2;
  localparam int CBWA_DIAG_W = 2;
  localparam logic CBWA_ASSERTED = 1'b0;
  localparam logic CBWA_NEGATED = 1'b1;
  localparam logic [1:0] CBWA_SYNC_RST = 2'h3;
  typedef enum logic [2:0] {
    CBWA_IDLE = 3'b000,
    CBWA_ADDR = 3'b001,
    CBWA_DATA = 3'b010,
    CBWA_WAIT = 3'b011,
    CBWA_GRANT = 3'b100
  } cbwa_state_e;
endpackage : cbwa_pkg

/* cbwa_bus_if.sv */
// interface: processor memory bus between processor end and memory/dma end
`timescale 1ns/1ns
interface cbwa_bus_if;
  import cbwa_pkg::*;
  logic [CBWA_AD_W-1:0] cpu_ad_o;
  logic cpu_ad_oe_n;
  logic [CBWA_AD_W-1:0] ext_ad_o;
  logic ext_ad_oe_n;
  logic [CBWA_IDX_W-1:0] low_word_index;
  logic [CBWA_DIAG_W-1:0] debug_status_out;
  logic read_strobe_n;
  logic store_strobe_n;
  logic data_drive_enable_n;
  logic multiword_or_samepage_n;
  logic address_latch_strobe;
  logic ctl_oe_n;
  logic cycle_done_n;
  logic transfer_fault_n;
  logic read_data_strobe_n;
  logic mastership_ask_n;
  logic mastership_given_n;
  logic system_clock_out;
  modport cpu (
    output cpu_ad_o, cpu_ad_oe_n, low_word_index, debug_status_out, read_strobe_n,
    output store_strobe_n, data_drive_enable_n, multiword_or_samepage_n,
    output address_latch_strobe, ctl_oe_n, mastership_given_n, system_clock_out,
    input ext_ad_o, ext_ad_oe_n, cycle_done_n, transfer_fault_n, read_data_strobe_n,
    input mastership_ask_n
  );
  modport mem (
    input cpu_ad_o, cpu_ad_oe_n, low_word_index, debug_status_out, read_strobe_n,
    input store_strobe_n, data_drive_enable_n, multiword_or_samepage_n,
    input address_latch_strobe, ctl_oe_n, mastership_given_n, system_clock_out,
    output ext_ad_o, ext_ad_oe_n, cycle_done_n, transfer_fault_n, read_data_strobe_n,
    output mastership_ask_n
  );
endinterface : cbwa_bus_if

/* cbwa_sync2.sv */
// module: two-flop synchroniser for an asynchronous level
`timescale 1ns/1ns
module cbwa_sync2 (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);
  import cbwa_pkg::*;
  logic [1:0] stage_ff;
  logic [1:0] nxt_stage;
  always_comb begin
    nxt_stage = {stage_ff[0], async_in};
  end
  // resets to the negated level so no grant appears out of reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage_ff <= CBWA_SYNC_RST;
    end else begin
      stage_ff <= nxt_stage;
    end
  end
  assign sync_out = stage_ff[1];
endmodule : cbwa_sync2

/* cbwa_cpu_end.sv */
// module: processor end - write engine termination and dma arbiter
`timescale 1ns/1ns
// Notes on behaviour
// - memory ends writes by done or fault
// - fault terminates write exactly like done
// - faulted write: no exception, no retry
// - sample termination once store data driven
// - no done at edge means wait cycle
// - dma request wins the next arbitration
// - grant only when bus free, after transfer
// - float bus outputs while granted
// - ignore strobes, done and fault while granted
// - run from caches, stall only for bus
// - drop grant on falling edge after negation
// - resume driving on following rising edge
// - new transfer right after negation sampled
// - dma master releases drivers by then
// - request held whole transfer; bus stays lent
// - synchronise asynchronous request before arbiter
// - dma master may use same controls
// - no hardware coherency with caches
module cbwa_cpu_end (
  input wire logic clock,
  input wire logic reset_n,
  cbwa_bus_if.cpu bus,
  input wire logic wr_req,
  input wire logic [cbwa_pkg::CBWA_AD_W-1:0] wr_addr,
  input wire logic [cbwa_pkg::CBWA_AD_W-1:0] wr_data,
  input wire logic wr_near,
  output logic wr_busy,
  output logic wr_done,
  output logic wr_fault,
  output logic dma_owned
);
  import cbwa_pkg::*;
  // ************************************************************
  // request synchroniser
  // ************************************************************
  logic ask_sync_n;
  cbwa_sync2 u_ask_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(bus.mastership_ask_n),
    .sync_out(ask_sync_n)
  );
  // ************************************************************
  // state
  // ************************************************************
  cbwa_state_e state_ff, nxt_state;
  logic [CBWA_AD_W-1:0] ad_ff, nxt_ad;
  logic [CBWA_IDX_W-1:0] idx_ff, nxt_idx;
  logic ad_oe_n_ff, nxt_ad_oe_n;
  logic ctl_oe_n_ff, nxt_ctl_oe_n;
  logic ale_ff, nxt_ale;
  logic wr_n_ff, nxt_wr_n;
  logic den_n_ff, nxt_den_n;
  logic near_n_ff, nxt_near_n;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic fault_ff, nxt_fault;
  logic owned_ff, nxt_owned;
  logic gnt_neg_ff, nxt_gnt_neg;
  logic gnt_fall_ff;
  logic term;
  always_comb begin
    // fault and done end a write identically; fault only flagged, never retried
    term = (bus.cycle_done_n == CBWA_ASSERTED) || (bus.transfer_fault_n == CBWA_ASSERTED);
    nxt_state = state_ff;
    nxt_ad = ad_ff;
    nxt_idx = idx_ff;
    nxt_ad_oe_n = ad_oe_n_ff;
    nxt_ctl_oe_n = ctl_oe_n_ff;
    nxt_ale = 1'b0;
    nxt_wr_n = wr_n_ff;
    nxt_den_n = den_n_ff;
    nxt_near_n = near_n_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_fault = 1'b0;
    nxt_owned = owned_ff;
    nxt_gnt_neg = gnt_neg_ff;
    case (state_ff)
      CBWA_IDLE: begin
        // drivers come back one edge after the grant flop clears
        nxt_ad_oe_n = 1'b0;
        nxt_ctl_oe_n = 1'b0;
        if (ask_sync_n == CBWA_ASSERTED) begin
          // dma beats a waiting write; bus is free here
          nxt_state = CBWA_GRANT;
          nxt_gnt_neg = CBWA_ASSERTED;
          nxt_ad_oe_n = 1'b1;
          nxt_ctl_oe_n = 1'b1;
          nxt_owned = 1'b1;
          nxt_busy = wr_req;
        end else if (wr_req) begin
          nxt_state = CBWA_ADDR;
          nxt_ad = wr_addr;
          nxt_idx = wr_addr[CBWA_IDX_W+1:2];
          nxt_ale = 1'b1;
          nxt_wr_n = CBWA_ASSERTED;
          nxt_near_n = wr_near ? CBWA_ASSERTED : CBWA_NEGATED;
          nxt_busy = 1'b1;
        end else begin
          nxt_busy = 1'b0;
        end
      end
      CBWA_ADDR: begin
        // second phase: store data replaces the address
        nxt_state = CBWA_DATA;
        nxt_ad = wr_data;
        nxt_den_n = CBWA_ASSERTED;
      end
      CBWA_DATA, CBWA_WAIT: begin
        if (term) begin
          nxt_state = CBWA_IDLE;
          nxt_wr_n = CBWA_NEGATED;
          nxt_den_n = CBWA_NEGATED;
          nxt_near_n = CBWA_NEGATED;
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
          nxt_fault = (bus.transfer_fault_n == CBWA_ASSERTED);
        end else begin
          nxt_state = CBWA_WAIT;
        end
      end
      CBWA_GRANT: begin
        // done, fault and read strobes are not looked at here
        // dma words are never snooped; software keeps caches coherent
        nxt_busy = wr_req;
        if (ask_sync_n == CBWA_NEGATED) begin
          nxt_state = CBWA_IDLE;
          // drivers stay off here; idle turns them on one edge later
          nxt_gnt_neg = CBWA_NEGATED;
          nxt_owned = 1'b0;
        end
      end
      default: begin
        nxt_state = CBWA_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= CBWA_IDLE;
      ad_ff <= '0;
      idx_ff <= '0;
      ad_oe_n_ff <= 1'b0;
      ctl_oe_n_ff <= 1'b0;
      ale_ff <= 1'b0;
      wr_n_ff <= CBWA_NEGATED;
      den_n_ff <= CBWA_NEGATED;
      near_n_ff <= CBWA_NEGATED;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      fault_ff <= 1'b0;
      owned_ff <= 1'b0;
      gnt_neg_ff <= CBWA_NEGATED;
    end else begin
      state_ff <= nxt_state;
      ad_ff <= nxt_ad;
      idx_ff <= nxt_idx;
      ad_oe_n_ff <= nxt_ad_oe_n;
      ctl_oe_n_ff <= nxt_ctl_oe_n;
      ale_ff <= nxt_ale;
      wr_n_ff <= nxt_wr_n;
      den_n_ff <= nxt_den_n;
      near_n_ff <= nxt_near_n;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      fault_ff <= nxt_fault;
      owned_ff <= nxt_owned;
      gnt_neg_ff <= nxt_gnt_neg;
    end
  end
  // ************************************************************
  // grant pin: asserts on rising, negates on the falling edge half a cycle later
  // ************************************************************
  // falling-edge copy lets the grant drop before our next strobe
  always_ff @(negedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gnt_fall_ff <= CBWA_NEGATED;
    end else begin
      gnt_fall_ff <= gnt_neg_ff;
    end
  end
  always_comb begin
    // low as soon as the rising flop asks, high only once the falling copy agrees
    // so the grant is gone half a cycle before our drivers return
    bus.mastership_given_n = gnt_neg_ff & gnt_fall_ff;
  end
  assign bus.system_clock_out = clock;
  assign bus.cpu_ad_o = ad_ff;
  assign bus.cpu_ad_oe_n = ad_oe_n_ff;
  assign bus.ctl_oe_n = ctl_oe_n_ff;
  assign bus.low_word_index = idx_ff;
  assign bus.debug_status_out = {owned_ff, busy_ff};
  assign bus.read_strobe_n = CBWA_NEGATED;
  assign bus.store_strobe_n = wr_n_ff;
  assign bus.data_drive_enable_n = den_n_ff;
  assign bus.multiword_or_samepage_n = near_n_ff;
  assign bus.address_latch_strobe = ale_ff;
  assign wr_busy = busy_ff;
  assign wr_done = done_ff;
  assign wr_fault = fault_ff;
  assign dma_owned = owned_ff;
endmodule : cbwa_cpu_end

/* cbwa_mem_end.sv */
// module: memory controller and dma master end
`timescale 1ns/1ns
module cbwa_mem_end #(
  parameter int WAIT_CYCLES = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  cbwa_bus_if.mem bus,
  input wire logic fault_sel,
  input wire logic dma_want,
  input wire logic [cbwa_pkg::CBWA_AD_W-1:0] dma_data,
  output logic [cbwa_pkg::CBWA_AD_W-1:0] seen_data,
  output logic seen_valid,
  output logic dma_active
);
  import cbwa_pkg::*;
  if (WAIT_CYCLES < 0 || WAIT_CYCLES > 255) begin : g_bad_wait
    $error("WAIT_CYCLES out of range");
  end
  // ************************************************************
  // write termination and dma ownership
  // ************************************************************
  logic [7:0] cnt_ff, nxt_cnt;
  logic done_n_ff, nxt_done_n;
  logic fault_n_ff, nxt_fault_n;
  logic ask_n_ff, nxt_ask_n;
  logic drive_n_ff, nxt_drive_n;
  logic [CBWA_AD_W-1:0] seen_ff, nxt_seen;
  logic seen_v_ff, nxt_seen_v;
  logic in_write;
  always_comb begin
    in_write = (bus.store_strobe_n == CBWA_ASSERTED) && (bus.data_drive_enable_n == CBWA_ASSERTED);
    nxt_cnt = cnt_ff;
    nxt_done_n = CBWA_NEGATED;
    nxt_fault_n = CBWA_NEGATED;
    nxt_seen = seen_ff;
    nxt_seen_v = 1'b0;
    // hold request for whole transfer; drop drivers on the same edge as the request
    nxt_ask_n = dma_want ? CBWA_ASSERTED : CBWA_NEGATED;
    nxt_drive_n = !(dma_want && bus.mastership_given_n == CBWA_ASSERTED);
    if (drive_n_ff == 1'b0) begin
      // memory answers the dma master a word a clock; the cpu must not react
      nxt_done_n = CBWA_ASSERTED;
    end else if (in_write && done_n_ff == CBWA_NEGATED && fault_n_ff == CBWA_NEGATED) begin
      if (cnt_ff >= 8'(WAIT_CYCLES)) begin
        nxt_cnt = '0;
        nxt_done_n = fault_sel ? CBWA_NEGATED : CBWA_ASSERTED;
        nxt_fault_n = fault_sel ? CBWA_ASSERTED : CBWA_NEGATED;
        nxt_seen = bus.cpu_ad_o;
        nxt_seen_v = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      done_n_ff <= CBWA_NEGATED;
      fault_n_ff <= CBWA_NEGATED;
      ask_n_ff <= CBWA_NEGATED;
      drive_n_ff <= 1'b1;
      seen_ff <= '0;
      seen_v_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_n_ff <= nxt_done_n;
      fault_n_ff <= nxt_fault_n;
      ask_n_ff <= nxt_ask_n;
      drive_n_ff <= nxt_drive_n;
      seen_ff <= nxt_seen;
      seen_v_ff <= nxt_seen_v;
    end
  end
  assign bus.cycle_done_n = done_n_ff;
  assign bus.transfer_fault_n = fault_n_ff;
  assign bus.read_data_strobe_n = CBWA_NEGATED;
  assign bus.mastership_ask_n = ask_n_ff;
  assign bus.ext_ad_o = dma_data;
  assign bus.ext_ad_oe_n = drive_n_ff;
  assign seen_data = seen_ff;
  assign seen_valid = seen_v_ff;
  assign dma_active = !drive_n_ff;
endmodule : cbwa_mem_end

/* cbwa_checker.sv */
// checker: write termination and dma hand-over properties on the bus
`timescale 1ns/1ns
module cbwa_checker (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cpu_ad_oe_n,
  input wire logic ctl_oe_n,
  input wire logic store_strobe_n,
  input wire logic data_drive_enable_n,
  input wire logic address_latch_strobe,
  input wire logic cycle_done_n,
  input wire logic transfer_fault_n,
  input wire logic mastership_ask_n,
  input wire logic mastership_given_n
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  a_fault_ends_write: assert property (
    !transfer_fault_n && !store_strobe_n && mastership_given_n |=> store_strobe_n)
    else $error("fault left write open");
  a_done_ends_write: assert property (
    !cycle_done_n && !store_strobe_n && mastership_given_n |=> store_strobe_n)
    else $error("done left write open");
  a_wait_holds_strobe: assert property (
    !store_strobe_n && cycle_done_n && transfer_fault_n && mastership_given_n
    |=> !store_strobe_n)
    else $error("write ended without done");
  a_data_phase_drive: assert property (
    address_latch_strobe |=> !address_latch_strobe && !data_drive_enable_n && !cpu_ad_oe_n)
    else $error("no data phase after address");
  a_float_granted: assert property (
    !mastership_given_n |-> ctl_oe_n && cpu_ad_oe_n)
    else $error("driving while granted");
  a_grant_bus_free: assert property (
    $fell(mastership_given_n) |-> store_strobe_n && $past(store_strobe_n))
    else $error("grant during write");
  a_grant_after_sync: assert property (
    $fell(mastership_given_n) |-> !$past(mastership_ask_n, 3))
    else $error("grant without synchronised ask");
  a_grant_held: assert property (
    !mastership_ask_n && !mastership_given_n |=> !mastership_given_n)
    else $error("grant lost while asked");
  a_release_bound: assert property (
    $rose(mastership_ask_n) && !mastership_given_n
    |-> ##[2:5] (mastership_given_n && !ctl_oe_n && !cpu_ad_oe_n))
    else $error("bus not returned in time");
  a_resume_drive: assert property (
    $rose(mastership_given_n) |-> (ctl_oe_n && cpu_ad_oe_n) ##1 (!ctl_oe_n && !cpu_ad_oe_n))
    else $error("drivers not resumed");
  a_one_ending: assert property (
    !(!cycle_done_n && !transfer_fault_n))
    else $error("done and fault together");
  c_fault_write: cover property (!transfer_fault_n && !store_strobe_n);
  c_grant: cover property ($fell(mastership_given_n));
  c_release: cover property ($rose(mastership_given_n));
endmodule : cbwa_checker

/* cbwa_tb.sv */
// testbench: write endings and dma hand-over across both ends
`timescale 1ns/1ns
module cbwa_tb;
  import cbwa_pkg::*;
  // ****
  // bench
  // ****
  localparam int WAIT_C = 2;
  logic clock, reset_n, wr_req, wr_near, fault_sel, dma_want;
  logic [CBWA_AD_W-1:0] wr_addr, wr_data, dma_data, seen_data;
  logic wr_busy, wr_done, wr_fault, dma_owned, seen_valid, dma_active;
  int error_cnt = 0;
  int checks_done = 0;
  int seen_cnt = 0;
  cbwa_bus_if bus ();
  cbwa_cpu_end u_cbwa_cpu_end (.clock(clock), .reset_n(reset_n), .bus(bus.cpu),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_near(wr_near),
    .wr_busy(wr_busy), .wr_done(wr_done), .wr_fault(wr_fault), .dma_owned(dma_owned));
  cbwa_mem_end #(.WAIT_CYCLES(WAIT_C)) u_cbwa_mem_end (.clock(clock), .reset_n(reset_n),
    .bus(bus.mem), .fault_sel(fault_sel), .dma_want(dma_want), .dma_data(dma_data),
    .seen_data(seen_data), .seen_valid(seen_valid), .dma_active(dma_active));
  cbwa_checker u_cbwa_checker (.clock(clock), .reset_n(reset_n),
    .cpu_ad_oe_n(bus.cpu_ad_oe_n), .ctl_oe_n(bus.ctl_oe_n),
    .store_strobe_n(bus.store_strobe_n), .data_drive_enable_n(bus.data_drive_enable_n),
    .address_latch_strobe(bus.address_latch_strobe), .cycle_done_n(bus.cycle_done_n),
    .transfer_fault_n(bus.transfer_fault_n), .mastership_ask_n(bus.mastership_ask_n),
    .mastership_given_n(bus.mastership_given_n));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic start_wr(input logic [31:0] a, input logic [31:0] d, input logic f);
    wr_addr = a;
    wr_data = d;
    fault_sel = f;
    wr_req = 1'b1;
  endtask : start_wr
  // bounded wait; keep leaves the request up so a second write is pending at once
  task automatic wait_done(output int cyc, input logic keep);
    cyc = 0;
    while (wr_done !== 1'b1 && cyc < 50) begin
      tick(1);
      cyc++;
      if (seen_valid === 1'b1) begin
        seen_cnt++;
      end
    end
    wr_req = keep;
  endtask : wait_done
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // tests need about 55 cycles
  initial begin
    repeat (2000) @(posedge clock);
    error_cnt++;
    stop_test();
  end
  initial begin
    int cyc;
    reset_n = 1'b0;
    {wr_req, wr_near, fault_sel, dma_want} = 4'h0;
    {wr_addr, wr_data, dma_data} = '0;
    tick(5);
    reset_n = 1'b1;
    chk(32'({bus.mastership_given_n, bus.ctl_oe_n, bus.cpu_ad_oe_n}), 32'h4);
    chk(32'(bus.system_clock_out), 32'h1);
    for (int f = 0; f < 2; f++) begin
      tick(1);
      wr_near = f[0];
      start_wr(32'h1000_0004 + 32'(f * 16), 32'hA5A5_0000 + 32'(f), f[0]);
      tick(1);
      chk(bus.cpu_ad_o, 32'h1000_0004 + 32'(f * 16));
      chk(32'({bus.address_latch_strobe, bus.store_strobe_n}), 32'h2);
      chk(32'(bus.multiword_or_samepage_n), 32'(f == 0));
      chk(32'({bus.low_word_index, bus.debug_status_out, bus.read_strobe_n}), 32'h0B);
      wait_done(cyc, 1'b0);
      chk(32'(wr_fault), 32'(f));
      chk(32'(cyc + 1), 32'(WAIT_C + 4));
      chk(seen_data, 32'hA5A5_0000 + 32'(f));
      chk(32'(seen_cnt), 32'(f + 1));
      fault_sel = 1'b0;
      repeat (5) begin
        tick(1);
        chk(32'({wr_busy, bus.address_latch_strobe}), 32'h0);
      end
      $display("test write end %0d done", f);
    end
    tick(1);
    start_wr(32'h2000_0008, 32'h5A5A_1234, 1'b0);
    tick(1);
    dma_want = 1'b1;
    dma_data = 32'hC3C3_7E7E;
    wait_done(cyc, 1'b1);
    chk(32'(dma_owned), 32'h0);
    wr_data = 32'h0F0F_2222;
    cyc = 0;
    while (dma_owned !== 1'b1 && cyc < 10) begin
      tick(1);
      cyc++;
    end
    chk(32'(cyc <= 2), 32'h1);
    repeat (6) begin
      tick(1);
      chk(32'({bus.mastership_given_n, bus.cpu_ad_oe_n, bus.ctl_oe_n}), 32'h3);
      chk(32'({wr_busy, wr_done, dma_active}), 32'h5);
    end
    dma_want = 1'b0;
    cyc = 0;
    while (dma_owned !== 1'b0 && cyc < 10) begin
      tick(1);
      cyc++;
    end
    chk(32'(cyc <= 5), 32'h1);
    chk(32'({bus.mastership_given_n, bus.ctl_oe_n, bus.cpu_ad_oe_n}), 32'h3);
    #5;
    chk(32'({bus.mastership_given_n, bus.ctl_oe_n, bus.cpu_ad_oe_n}), 32'h7);
    tick(1);
    chk(32'({bus.mastership_given_n, bus.ctl_oe_n, bus.cpu_ad_oe_n}), 32'h4);
    chk(32'({bus.address_latch_strobe, bus.store_strobe_n}), 32'h2);
    chk(32'(bus.ext_ad_oe_n), 32'h1);
    wait_done(cyc, 1'b0);
    chk(32'({wr_done, wr_fault}), 32'h2);
    chk(seen_data, 32'h0F0F_2222);
    chk(32'(seen_cnt), 32'h4);
    $display("test dma hand-over done");
    tick(2);
    stop_test();
  end
endmodule : cbwa_tb
